// ---- verilog/eab_pkg.sv ----
// shared constants, types and helpers of the effective address unit
package eab_pkg;
	localparam logic [15:0] ABS8_FILL  = 16'hffff;
	localparam logic [7:0]  NORM_FILL  = 8'h00;
	localparam logic [15:0] MI_FILL    = 16'h0000;
	localparam logic [23:0] LONG_HALF  = 24'h000002;
	localparam logic [23:0] BYTE_NEXT  = 24'h000001;
	localparam logic [31:0] STEP_B     = 32'h00000001;
	localparam logic [31:0] STEP_W     = 32'h00000002;
	localparam logic [31:0] STEP_L     = 32'h00000004;
	localparam logic [31:0] REG_RST    = 32'h00000000;
	localparam logic        ADV_RST    = 1'b1;
	localparam logic [1:0]  LANE_HI    = 2'b10;
	localparam logic [1:0]  LANE_LO    = 2'b01;
	localparam logic [1:0]  LANE_BOTH  = 2'b11;
	localparam int          PTR_LSB    = 4;
	localparam int          INC_LSB    = 7;
	localparam int          BIT_LSB    = 4;
	localparam int          TRAP_LSB   = 4;

	typedef enum logic [3:0] {
		EM_RDIR, EM_RIND, EM_DISP16, EM_DISP24, EM_POSTINC, EM_PREDEC, EM_ABS8,
		EM_ABS16, EM_ABS24, EM_IMM, EM_PCREL8, EM_PCREL16, EM_MEMIND, EM_IMPL
	} eab_mode_t;
	typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} eab_size_t;
	typedef enum logic [1:0] {CL_ALU, CL_XFER, CL_BIT, CL_FLOW} eab_class_t;
	typedef enum logic [1:0] {IM_PTR, IM_INCDEC, IM_BITNUM, IM_TRAP} eab_impl_t;

	typedef struct packed {
		logic        valid;
		eab_class_t  cls;
		eab_mode_t   mode;
		eab_size_t   size;
		logic        write;
		logic        bit_from_reg;
		logic [3:0]  rfield;
		logic [3:0]  bit_reg;
		eab_impl_t   impl;
		logic [15:0] opword;
		logic [31:0] ext;
		logic [23:0] pc_next;
		logic [31:0] wdata;
	} eab_req_t;

	typedef struct packed {
		logic        valid;
		logic        illegal;
		logic        odd_target;
		logic [23:0] ea;
		logic [31:0] data;
		logic [2:0]  bit_num;
	} eab_rsp_t;

	typedef struct packed {
		logic periph;
		logic three_state;
		logic narrow;
	} eab_attr_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [1:0]  lane;
		logic [23:0] addr;
		logic [15:0] wdata;
	} eab_bus_t;

	function automatic logic [23:0] eab_trunc(input logic [23:0] a, input logic adv);
		return adv ? a : {NORM_FILL, a[15:0]};
	endfunction

	function automatic logic [31:0] eab_step(input eab_size_t s);
		return (s == SZ_B) ? STEP_B : (s == SZ_W) ? STEP_W : STEP_L;
	endfunction
endpackage

// ---- verilog/eab_regfile.sv ----
// eight long registers, byte-writable, two combinational read ports
module eab_regfile
	import eab_pkg::*;
#(
	parameter int NREG = 8,
	parameter int W    = 32
) (
	input  wire logic [$clog2(NREG)-1:0] clk_unused_idx,
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [$clog2(NREG)-1:0] ra_idx,
	input  wire logic [$clog2(NREG)-1:0] rb_idx,
	input  wire logic [W/8-1:0]          we,
	input  wire logic [$clog2(NREG)-1:0] w_idx,
	input  wire logic [W-1:0]            w_data,
	output logic [W-1:0]                 ra_data,
	output logic [W-1:0]                 rb_data
);
	logic [W-1:0] mem_q [NREG];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				mem_q[i] <= W'(REG_RST);
			end
		end else begin
			for (int b = 0; b < W / 8; b++) begin
				if (we[b]) begin
					mem_q[w_idx][8*b +: 8] <= w_data[8*b +: 8];
				end
			end
		end
	end

	assign ra_data = mem_q[ra_idx];
	assign rb_data = mem_q[rb_idx];
endmodule

// ---- verilog/eab_bus_cycle.sv ----
// internal bus cycle: two or three states, byte lanes, narrow-register split
module eab_bus_cycle
	import eab_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [23:0] addr,
	input  wire logic        word,
	input  wire logic        write,
	input  wire logic [15:0] wdata,
	input  wire eab_attr_t   attr,
	input  wire logic [15:0] rdata,
	output eab_bus_t         bus_q,
	output logic             done_q,
	output logic             err_q,
	output logic [15:0]      rdata_q
);
	typedef enum logic [1:0] {
		BC_IDLE = 2'b00, BC_T1 = 2'b01, BC_T2 = 2'b11, BC_T3 = 2'b10
	} eab_bstate_t;

	eab_bstate_t state_q;
	eab_attr_t   attr_q;
	logic        word_q;
	logic        write_q;
	logic        second_q;
	logic [15:0] wdata_q;
	logic        refuse_now;
	logic        refuse;
	logic        split;
	logic        wait3;
	logic        last;
	logic [7:0]  byte_in;

	// attributes come from the decoder watching the address driven in T1
	assign refuse_now = attr.periph && !attr.narrow && !word_q; // RQ18
	assign refuse     = state_q == BC_T2 && attr_q.periph && !attr_q.narrow && !word_q;
	assign split      = attr_q.periph && attr_q.narrow && word_q && !second_q; // RQ19
	assign wait3      = attr_q.periph && attr_q.three_state; // RQ18
	assign last       = (state_q == BC_T2 && !wait3) || state_q == BC_T3; // RQ16
	assign byte_in    = bus_q.addr[0] ? rdata[7:0] : rdata[15:8]; // RQ22

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= BC_IDLE;
		end else begin
			unique case (state_q)
				BC_IDLE: if (start) state_q <= BC_T1;
				BC_T1:   state_q <= BC_T2;
				BC_T2: begin
					if (refuse) state_q <= BC_IDLE;
					else if (wait3) state_q <= BC_T3; // RQ18
					else if (split) state_q <= BC_T1; // RQ19
					else state_q <= BC_IDLE; // RQ17 RQ20
				end
				BC_T3:   state_q <= split ? BC_T1 : BC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			attr_q <= '0;
		end else if (state_q == BC_T1) begin
			attr_q <= attr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_q   <= 1'b0;
			write_q  <= 1'b0;
			wdata_q  <= 16'h0000;
			second_q <= 1'b0;
		end else if (state_q == BC_IDLE && start) begin
			word_q   <= word;
			write_q  <= write;
			wdata_q  <= wdata;
			second_q <= 1'b0;
		end else if (last && split) begin
			second_q <= 1'b1;
		end
	end

	// lanes and write strobe only from T2, once the register width is known
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_q <= '0;
		end else if (state_q == BC_IDLE && start) begin
			bus_q.addr <= addr;
			bus_q.rd   <= !write;
			bus_q.wr   <= 1'b0;
			bus_q.lane <= 2'b00;
		end else if (state_q == BC_T1) begin
			bus_q.wr <= write_q && !refuse_now; // RQ18
			if (attr.periph && attr.narrow && word_q) begin
				bus_q.lane  <= second_q ? LANE_LO : LANE_HI; // RQ19
				bus_q.wdata <= second_q ? {2{wdata_q[7:0]}} : {2{wdata_q[15:8]}};
			end else if (word_q) begin
				bus_q.lane  <= LANE_BOTH; // RQ17
				bus_q.wdata <= wdata_q;
			end else begin
				bus_q.lane  <= bus_q.addr[0] ? LANE_LO : LANE_HI; // RQ22
				bus_q.wdata <= {2{wdata_q[7:0]}};
			end
		end else if (last || refuse) begin
			bus_q.rd   <= 1'b0;
			bus_q.wr   <= 1'b0;
			bus_q.lane <= 2'b00;
			if (split && !refuse) begin
				bus_q.addr <= bus_q.addr + BYTE_NEXT; // RQ19
				bus_q.rd   <= !write_q;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			done_q <= last && !refuse && !split;
			err_q  <= refuse;
			if (last && !refuse) begin
				if (split) rdata_q[15:8] <= byte_in;
				else if (second_q) rdata_q[7:0] <= byte_in;
				else if (word_q) rdata_q <= rdata;
				else rdata_q <= {8'h00, byte_in};
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_mem_two_state: assert property ( // RQ17
		(state_q == BC_T1 && !attr.periph) |-> ##2 done_q)
		else $error("memory access not two states");
	a_periph_three: assert property ( // RQ18
		(state_q == BC_T1 && attr.periph && attr.three_state && !refuse_now
			&& !(attr.narrow && word_q && !second_q))
		|-> ##1 !done_q ##1 !done_q ##1 done_q)
		else $error("three state access wrong length");
	a_narrow_split: assert property ( // RQ19
		(state_q == BC_T1 && attr.periph && attr.narrow && word_q && !second_q)
		|-> ##[2:3] (state_q == BC_T1 && second_q))
		else $error("narrow word not split");
	a_wide_refuse: assert property ( // RQ18
		(state_q == BC_T1 && refuse_now) |=> !bus_q.wr ##1 (err_q && !done_q))
		else $error("byte access to wide register not refused");
	c_split: cover property (state_q == BC_T1 && second_q);
endmodule

// ---- verilog/eab_ea_unit.sv ----
// effective address unit: mode decode, address arithmetic, operand access
// Function
// RQ1: register direct picks byte half, word half or whole long register
// RQ2: register indirect addresses memory with low 24 register bits
// RQ3: displacement, 16-bit sign-extended or 24-bit, added to register
// RQ4: post-increment addresses with register, then pointer_add_immediate 1, 2 or 4
// RQ5: pre-decrement subtracts 1, 2 or 4 first, stores, then addresses
// RQ6: short absolute fills upper sixteen bits with ones; long reaches all
// RQ7: 16-bit absolute sign-extends bit 15 into upper byte
// RQ8: immediate takes 8, 16 or 32 bits from instruction stream
// RQ9: implicit immediates for pointer step, increment, bit number, trap vector
// RQ10: branch target is next-instruction counter plus sign-extended displacement
// RQ11: short and long branch ranges follow; odd targets are flagged
// RQ12: memory indirect reads long at zero-extended byte address, keeps 24 bits
// RQ13: normal mode drops upper address byte; advanced keeps 24 bits
// RQ14: arithmetic only register direct or immediate; transfers exclude branch modes
// RQ15: bit operations use direct, indirect or short absolute; number from register
// RQ16: one state per clock edge; bus cycles two or three states
// RQ17: on-chip memory takes two states, 16-bit path, byte or word
// RQ18: peripheral two or three states; wide registers take words only
// RQ19: word access to narrow register becomes two byte cycles
// RQ20: two-state peripheral access times like on-chip memory
// RQ21: address register field three bits; data register field three or four
// RQ22: byte access picks lane from address bit 0, other lane untouched
module eab_ea_unit
	import eab_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        ADV_MODE,
	input  wire eab_req_t    REQ,
	input  wire eab_attr_t   BUS_ATTR,
	input  wire logic [15:0] BUS_RDATA,
	output logic             REQ_READY,
	output eab_rsp_t         RSP,
	output eab_bus_t         BUS
);
	typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_ACC = 2'b01, MS_ACC2 = 2'b11} eab_mstate_t;

	eab_mstate_t state_q;
	logic [2:0]  sync_q;
	logic        adv_q;
	eab_req_t    req_q;
	logic [23:0] ea_q;
	logic [15:0] hi_q;
	eab_rsp_t    rsp_q;
	logic        ready_q;
	logic        bc_start_q;
	logic [23:0] bc_addr_q;
	logic        bc_word_q;
	logic        bc_write_q;
	logic [15:0] bc_wdata_q;
	logic        bc_done;
	logic        bc_err;
	logic [15:0] bc_rdata;
	logic [31:0] ra_data;
	logic [31:0] rb_data;
	logic [23:0] ra_lo;
	logic [2:0]  ra_idx;
	logic [3:0]  we;
	logic [2:0]  w_idx;
	logic [31:0] w_data;
	logic        accept;
	logic        legal;
	logic        is_mem;
	logic        long_q;
	logic        fin;
	logic [23:0] sx16;
	logic [23:0] ea_c;
	logic [31:0] dec_c;
	logic [31:0] inc_c;
	logic [31:0] rdir_c;
	logic [31:0] imm_c;
	logic [2:0]  bitn_c;
	logic        pcrel;

	// mode pin: three stages, the change taken once second and third agree
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			sync_q <= {3{ADV_RST}};
			adv_q  <= ADV_RST;
		end else begin
			sync_q <= {sync_q[1:0], ADV_MODE};
			if (sync_q[1] == sync_q[2]) adv_q <= sync_q[2];
		end
	end

	assign accept = REQ.valid && ready_q;
	assign ra_idx = (state_q == MS_IDLE) ? REQ.rfield[2:0] : req_q.rfield[2:0]; // RQ21
	assign ra_lo  = ra_data[23:0]; // RQ2
	assign sx16   = {{8{REQ.ext[15]}}, REQ.ext[15:0]};
	assign dec_c  = ra_data - eab_step(REQ.size); // RQ5
	assign inc_c  = ra_data + eab_step(req_q.size); // RQ4
	assign pcrel  = REQ.mode inside {EM_PCREL8, EM_PCREL16};
	assign long_q = req_q.size == SZ_L || req_q.mode == EM_MEMIND;
	assign fin    = bc_done && (state_q == MS_ACC2 || (state_q == MS_ACC && !long_q));
	assign is_mem = (REQ.cls != CL_FLOW && !(REQ.mode inside {EM_RDIR, EM_IMM, EM_IMPL}))
		|| REQ.mode == EM_MEMIND;

	eab_regfile #(
		.NREG (8),
		.W    (32)
	) u_regs (
		.clk_unused_idx (3'h0),
		.clk            (REF_CLK),
		.rst            (RESET),
		.ra_idx         (ra_idx),
		.rb_idx         (REQ.bit_reg[2:0]),
		.we             (we),
		.w_idx          (w_idx),
		.w_data         (w_data),
		.ra_data        (ra_data),
		.rb_data        (rb_data)
	);

	always_comb begin
		unique case (REQ.cls)
			CL_ALU:  legal = REQ.mode inside {EM_RDIR, EM_IMM, EM_IMPL}; // RQ14
			CL_XFER: legal = !(REQ.mode inside {EM_PCREL8, EM_PCREL16, EM_MEMIND}); // RQ14
			CL_BIT:  legal = REQ.mode inside {EM_RDIR, EM_RIND, EM_ABS8}; // RQ15
			CL_FLOW: legal = REQ.mode inside {EM_PCREL8, EM_PCREL16, EM_MEMIND, EM_RIND,
				EM_ABS24, EM_IMPL};
		endcase
	end

	always_comb begin
		unique case (REQ.mode)
			EM_DISP16:  ea_c = ra_lo + sx16; // RQ3
			EM_DISP24:  ea_c = ra_lo + REQ.ext[23:0]; // RQ3
			EM_PREDEC:  ea_c = dec_c[23:0]; // RQ5
			EM_ABS8:    ea_c = {ABS8_FILL, REQ.ext[7:0]}; // RQ6
			EM_ABS16:   ea_c = sx16; // RQ7
			EM_ABS24:   ea_c = REQ.ext[23:0]; // RQ6
			EM_PCREL8:  ea_c = REQ.pc_next + {{16{REQ.ext[7]}}, REQ.ext[7:0]}; // RQ10 RQ11
			EM_PCREL16: ea_c = REQ.pc_next + sx16; // RQ10 RQ11
			EM_MEMIND:  ea_c = {MI_FILL, REQ.ext[7:0]}; // RQ12
			default:    ea_c = ra_lo; // RQ2 RQ4
		endcase
	end

	always_comb begin
		unique case (REQ.size)
			SZ_B:    rdir_c = {24'h000000, REQ.rfield[3] ? ra_data[7:0] : ra_data[15:8]}; // RQ1
			SZ_W:    rdir_c = {16'h0000, REQ.rfield[3] ? ra_data[31:16] : ra_data[15:0]}; // RQ1
			default: rdir_c = ra_data; // RQ1
		endcase
	end

	always_comb begin
		imm_c = 32'h00000000;
		if (REQ.mode == EM_IMM) begin
			unique case (REQ.size)
				SZ_B:    imm_c = {24'h000000, REQ.ext[7:0]}; // RQ8
				SZ_W:    imm_c = {16'h0000, REQ.ext[15:0]}; // RQ8
				default: imm_c = REQ.ext; // RQ8
			endcase
		end else if (REQ.mode == EM_IMPL) begin
			unique case (REQ.impl)
				IM_PTR: begin
					unique case (REQ.opword[PTR_LSB +: 2])
						2'h0:    imm_c = STEP_B; // RQ9
						2'h1:    imm_c = STEP_W; // RQ9
						default: imm_c = STEP_L; // RQ9
					endcase
				end
				IM_INCDEC: imm_c = REQ.opword[INC_LSB] ? STEP_W : STEP_B; // RQ9
				IM_BITNUM: imm_c = {29'h00000000, REQ.opword[BIT_LSB +: 3]}; // RQ9
				IM_TRAP:   imm_c = {30'h00000000, REQ.opword[TRAP_LSB +: 2]}; // RQ9
			endcase
		end else begin
			imm_c = rdir_c;
		end
	end

	// a register number takes the low bits of the selected byte half
	assign bitn_c = !REQ.bit_from_reg ? REQ.opword[BIT_LSB +: 3] // RQ15
		: REQ.bit_reg[3] ? rb_data[2:0] : rb_data[10:8]; // RQ15

	// the three writers never meet: two only in idle, one only on finish
	always_comb begin
		we     = 4'h0;
		w_idx  = ra_idx;
		w_data = 32'h00000000;
		if (accept && legal && REQ.mode == EM_PREDEC) begin
			we     = 4'hf; // RQ5
			w_data = dec_c;
		end else if (accept && legal && REQ.mode == EM_RDIR && REQ.write) begin
			unique case (REQ.size)
				SZ_B:    we = REQ.rfield[3] ? 4'h1 : 4'h2; // RQ1
				SZ_W:    we = REQ.rfield[3] ? 4'hc : 4'h3; // RQ1
				default: we = 4'hf;
			endcase
			w_data = REQ.size == SZ_B ? {4{REQ.wdata[7:0]}}
				: REQ.size == SZ_W ? {2{REQ.wdata[15:0]}} : REQ.wdata;
		end else if (fin && req_q.mode == EM_POSTINC) begin
			we     = 4'hf; // RQ4
			w_data = inc_c;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_q <= MS_IDLE;
			ready_q <= 1'b1;
		end else begin
			unique case (state_q)
				MS_IDLE: if (accept && legal && is_mem) begin
					state_q <= MS_ACC;
					ready_q <= 1'b0;
				end
				MS_ACC: if (bc_err || fin) begin
					state_q <= MS_IDLE;
					ready_q <= 1'b1;
				end else if (bc_done) begin
					state_q <= MS_ACC2;
				end
				MS_ACC2: if (bc_err || bc_done) begin
					state_q <= MS_IDLE;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			req_q <= '0;
			ea_q  <= 24'h000000;
			hi_q  <= 16'h0000;
		end else begin
			if (accept) begin
				req_q <= REQ;
				ea_q  <= ea_c;
			end
			if (state_q == MS_ACC && bc_done) hi_q <= bc_rdata;
		end
	end

	// a long operand is two word cycles, upper half at the lower address
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			bc_start_q <= 1'b0;
			bc_addr_q  <= 24'h000000;
			bc_word_q  <= 1'b0;
			bc_write_q <= 1'b0;
			bc_wdata_q <= 16'h0000;
		end else begin
			bc_start_q <= 1'b0;
			if (accept && legal && is_mem) begin
				bc_start_q <= 1'b1;
				bc_addr_q  <= eab_trunc(ea_c, adv_q); // RQ13
				bc_word_q  <= REQ.size != SZ_B || REQ.mode == EM_MEMIND; // RQ12
				bc_write_q <= REQ.write && REQ.mode != EM_MEMIND;
				bc_wdata_q <= REQ.size == SZ_L ? REQ.wdata[31:16]
					: REQ.size == SZ_W ? REQ.wdata[15:0] : {8'h00, REQ.wdata[7:0]};
			end else if (state_q == MS_ACC && bc_done && long_q) begin
				bc_start_q <= 1'b1;
				bc_addr_q  <= eab_trunc(ea_q + LONG_HALF, adv_q); // RQ13
				bc_wdata_q <= req_q.wdata[15:0];
			end
		end
	end

	eab_bus_cycle u_bus (
		.clk     (REF_CLK),
		.rst     (RESET),
		.start   (bc_start_q),
		.addr    (bc_addr_q),
		.word    (bc_word_q),
		.write   (bc_write_q),
		.wdata   (bc_wdata_q),
		.attr    (BUS_ATTR),
		.rdata   (BUS_RDATA),
		.bus_q   (BUS),
		.done_q  (bc_done),
		.err_q   (bc_err),
		.rdata_q (bc_rdata)
	);

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= 1'b0;
			if (accept) begin
				rsp_q.bit_num <= bitn_c;
				if (!legal || !is_mem) begin
					rsp_q.valid      <= 1'b1;
					rsp_q.illegal    <= !legal; // RQ14 RQ15
					rsp_q.odd_target <= pcrel && ea_c[0]; // RQ11
					rsp_q.ea         <= eab_trunc(ea_c, adv_q); // RQ13
					rsp_q.data       <= imm_c;
				end
			end else if (fin || (state_q != MS_IDLE && bc_err)) begin
				rsp_q.valid      <= 1'b1;
				rsp_q.illegal    <= bc_err;
				rsp_q.odd_target <= 1'b0;
				if (req_q.mode == EM_MEMIND) begin
					rsp_q.ea   <= eab_trunc({hi_q[7:0], bc_rdata}, adv_q); // RQ12 RQ13
					rsp_q.data <= {8'h00, hi_q[7:0], bc_rdata};
				end else begin
					rsp_q.ea   <= eab_trunc(ea_q, adv_q); // RQ13
					rsp_q.data <= req_q.size == SZ_L ? {hi_q, bc_rdata} : {16'h0000, bc_rdata};
				end
			end
		end
	end

	assign REQ_READY = ready_q;
	assign RSP       = rsp_q;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	a_abs8_fill: assert property ( // RQ6
		(accept && REQ.mode == EM_ABS8) |=> ea_q[23:8] == ABS8_FILL)
		else $error("short absolute upper bits not ones");
	a_norm_trunc: assert property ( // RQ13
		(rsp_q.valid && !$past(adv_q)) |-> rsp_q.ea[23:16] == NORM_FILL)
		else $error("normal mode address not truncated");
	a_predec_long: assert property ( // RQ5
		(accept && legal && REQ.mode == EM_PREDEC && REQ.size == SZ_L)
		|=> ea_q == $past(ra_lo) - 24'h000004)
		else $error("pre-decrement address wrong");
	a_postinc_addr: assert property ( // RQ4
		(accept && legal && REQ.mode == EM_POSTINC) |=> ea_q == $past(ra_lo))
		else $error("post-increment address not the old register");
	a_alu_legal: assert property ( // RQ14
		(accept && REQ.cls == CL_ALU && !(REQ.mode inside {EM_RDIR, EM_IMM, EM_IMPL}))
		|=> rsp_q.valid && rsp_q.illegal)
		else $error("illegal arithmetic operand mode accepted");
	a_memind_zext: assert property ( // RQ12
		(accept && legal && REQ.mode == EM_MEMIND)
		|=> bc_addr_q[23:8] == MI_FILL && state_q == MS_ACC ##[3:12] rsp_q.valid)
		else $error("memory indirect fetch wrong");
	c_memind: cover property (rsp_q.valid && req_q.mode == EM_MEMIND && !rsp_q.illegal);
	c_postinc_long: cover property (accept && REQ.mode == EM_POSTINC && REQ.size == SZ_L);
endmodule

// ---- tb/eab_mem_model.sv ----
// on-chip memory and peripheral register model on the far side of the bus
module eab_mem_model
	import eab_pkg::*;
(
	input  wire logic     clk,
	input  wire eab_bus_t bus,
	output eab_attr_t     attr,
	output logic [15:0]   rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic [15:0] last_q;
	logic        periph;
	initial begin
		last_q = 16'h0000;
		for (int i = 0; i < 256; i++) begin
			mem[i] = {i[7:0], ~i[7:0]};
		end
	end
	// peripheral page ff1xxx; bit 8 marks three-state, bit 9 marks byte-wide
	// one driver for the whole attribute word
	assign periph = bus.addr[23:12] == 12'hff1;
	assign attr   = {periph, periph & bus.addr[8], periph & bus.addr[9]};
	// a released bus shows the inverse of its last value, never a stale match
	assign rdata = bus.rd ? mem[bus.addr[8:1]] : ~last_q;
	always @(posedge clk) begin
		if (bus.rd) begin
			last_q <= rdata;
		end
		if (bus.wr && bus.lane[1]) begin
			mem[bus.addr[8:1]][15:8] <= bus.wdata[15:8];
		end
		if (bus.wr && bus.lane[0]) begin
			mem[bus.addr[8:1]][7:0] <= bus.wdata[7:0];
		end
	end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the effective address unit
module testbench;
	import eab_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        adv = 1'b1;
	eab_req_t    req = '0;
	eab_attr_t   attr;
	logic [15:0] rdata;
	logic        ready;
	eab_rsp_t    rsp;
	eab_bus_t    bus;
	eab_rsp_t    s;
	int          lat;
	int          err_total = 0;
	int          n_compared = 0;

	always #2 clk = ~clk;

	eab_ea_unit dut (.REF_CLK(clk), .RESET(rst), .ADV_MODE(adv), .REQ(req), .BUS_ATTR(attr),
		.BUS_RDATA(rdata), .REQ_READY(ready), .RSP(rsp), .BUS(bus));
	eab_mem_model mem (.clk(clk), .bus(bus), .attr(attr), .rdata(rdata));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	function automatic eab_req_t mk(eab_class_t c, eab_mode_t m, eab_size_t z, logic [3:0] rf,
		logic [31:0] ext);
		eab_req_t r;
		r = '0;
		r.cls = c;
		r.mode = m;
		r.size = z;
		r.rfield = rf;
		r.ext = ext;
		return r;
	endfunction

	// holds the request through its accept edge; lat 1 is the cycle right after it,
	// so a one-cycle answer is seen while it stands; one idle cycle before returning
	task automatic xfer(input eab_req_t r);
		eab_req_t q;
		q = r;
		q.valid = 1'b1;
		req = q;
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		lat = 1;
		while (rsp.valid !== 1'b1 && lat < 20) begin
			@(posedge clk);
			#1;
			lat++;
		end
		s = rsp;
		if (rsp.valid !== 1'b1) begin
			err_total++;
		end
		@(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		chk(ready, 1'b1);
		chk(32'(rsp !== '0), 32'h0);
		chk(32'(bus !== '0), 32'h0);
	endtask

	task automatic t_regs();
		eab_req_t r;
		r = mk(CL_XFER, EM_RDIR, SZ_L, 4'h1, 32'h0);
		r.write = 1'b1;
		r.wdata = 32'h00001000;
		xfer(r);
		chk(lat, 1);
		xfer(mk(CL_XFER, EM_RIND, SZ_W, 4'h1, 32'h0));
		chk(s.ea, 24'h001000);
		chk(lat, 5);
		xfer(mk(CL_XFER, EM_POSTINC, SZ_W, 4'h1, 32'h0));
		chk(s.ea, 24'h001000);
		xfer(mk(CL_XFER, EM_RDIR, SZ_L, 4'h1, 32'h0));
		chk(s.data, 32'h00001002);
		xfer(mk(CL_XFER, EM_PREDEC, SZ_B, 4'h1, 32'h0));
		chk(s.ea, 24'h001001);
		xfer(mk(CL_XFER, EM_DISP16, SZ_B, 4'h1, 32'h0000fffe));
		chk(s.ea, 24'h000fff);
		xfer(mk(CL_XFER, EM_RDIR, SZ_B, 4'h1, 32'h0));
		chk(s.data, 32'h00000010);
		xfer(mk(CL_XFER, EM_DISP24, SZ_B, 4'h1, 32'h00010000));
		chk(s.ea, 24'h011001);
		xfer(mk(CL_XFER, EM_PREDEC, SZ_L, 4'h1, 32'h0));
		chk(s.ea, 24'h000ffd);
		chk(lat, 9);
	endtask

	task automatic t_abs();
		xfer(mk(CL_XFER, EM_ABS8, SZ_W, 4'h0, 32'h00000010));
		chk(s.ea, 24'hffff10);
		xfer(mk(CL_XFER, EM_ABS16, SZ_W, 4'h0, 32'h00008000));
		chk(s.ea, 24'hff8000);
		xfer(mk(CL_ALU, EM_IMM, SZ_L, 4'h0, 32'h12345678));
		chk(s.data, 32'h12345678);
		chk(lat, 1);
		xfer(mk(CL_ALU, EM_RIND, SZ_W, 4'h1, 32'h0));
		chk({s.illegal, lat[3:0]}, 5'h11);
	endtask

	task automatic t_mem();
		eab_req_t r;
		r = mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00000040);
		r.write = 1'b1;
		r.wdata = 32'h0000beef;
		xfer(r);
		xfer(mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00000040));
		chk(s.data[15:0], 16'hbeef);
		xfer(mk(CL_FLOW, EM_MEMIND, SZ_L, 4'h0, 32'h00000040));
		chk(s.ea, 24'hef21de);
		chk(lat, 9);
		xfer(mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00ff1100));
		chk(lat, 6);
		xfer(mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00ff1000));
		chk(lat, 5);
		r = mk(CL_XFER, EM_ABS24, SZ_B, 4'h0, 32'h00ff1000);
		r.write = 1'b1;
		r.wdata = 32'h000000aa;
		xfer(r);
		chk({s.illegal, lat[3:0]}, 5'h15);
		// the refused byte aliases the word read next: a leaked strobe shows there
		xfer(mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00ff1200));
		chk(s.data[15:0], 16'h00ff);
		chk(lat, 7);
	endtask

	task automatic t_branch();
		eab_req_t r;
		r = mk(CL_FLOW, EM_PCREL8, SZ_W, 4'h0, 32'h00000080);
		r.pc_next = 24'h000100;
		xfer(r);
		chk({s.odd_target, s.ea}, 25'h0000080);
		r.ext = 32'h00000001;
		xfer(r);
		chk({s.odd_target, s.ea}, 25'h1000101);
		r.mode = EM_PCREL16;
		r.ext = 32'h00008002;
		xfer(r);
		chk(s.ea, 24'hff8102);
	endtask

	task automatic t_misc();
		eab_req_t r;
		r = mk(CL_BIT, EM_RDIR, SZ_B, 4'h1, 32'h0);
		r.opword = 16'h0050;
		xfer(r);
		chk(s.bit_num, 3'h5);
		r.bit_from_reg = 1'b1;
		r.bit_reg = 4'h1;
		xfer(r);
		chk(s.bit_num, 3'h7);
		r = mk(CL_ALU, EM_IMPL, SZ_L, 4'h0, 32'h0);
		r.impl = IM_PTR;
		r.opword = 16'h0020;
		xfer(r);
		chk(s.data, 32'h00000004);
		r.impl = IM_TRAP;
		r.opword = 16'h0030;
		xfer(r);
		chk(s.data, 32'h00000003);
		adv = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		xfer(mk(CL_XFER, EM_ABS24, SZ_W, 4'h0, 32'h00ab0044));
		chk(s.ea, 24'h000044);
		adv = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	initial begin
		#20000;
		err_total++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clk);
		#1;
		t_reset();
		rst = 1'b0;
		t_regs();
		t_abs();
		t_mem();
		t_branch();
		t_misc();
		end_sim();
	end
endmodule
